// ---- core/sic_defs.svh ----
// Register offsets, write masks, reset values, bit positions and timing for the bank
`ifndef SIC_DEFS_SVH
`define SIC_DEFS_SVH
`define SIC_OFS_ALIAS 8'h08
`define SIC_OFS_CRCLO 8'h0A
`define SIC_OFS_CRCHI 8'h0B
`define SIC_OFS_STAT 8'h0C
`define SIC_OFS_GP0 8'h0D
`define SIC_OFS_GP21 8'h0E
`define SIC_OFS_O4G3 8'h0F
`define SIC_OFS_O65 8'h10
`define SIC_OFS_O7 8'h11
`define SIC_OFS_DPC 8'h12
`define SIC_OFS_MODE 8'h13
`define SIC_OFS_OSC 8'h14
`define SIC_OFS_WDC 8'h16
`define SIC_OFS_I2C 8'h17
`define SIC_MSK_ALIAS 8'hFE
`define SIC_MSK_GP0 8'h0F
`define SIC_MSK_GP21 8'hFF
`define SIC_MSK_O4G3 8'h9F
`define SIC_MSK_O65 8'h99
`define SIC_MSK_O7 8'h09
`define SIC_MSK_DPC 8'h36
`define SIC_MSK_OSC 8'h06
`define SIC_MSK_WDC 8'hFF
`define SIC_MSK_I2C 8'hFF
`define SIC_RST_ZERO 8'h00
`define SIC_RST_WDC 8'hFE
`define SIC_RST_I2C 8'h5E
`define SIC_DPC_DEPOL 5
`define SIC_DPC_I2SREGEN 4
`define SIC_DPC_V18 2
`define SIC_DPC_I2STRANS 1
`define SIC_WDC_DIS 0
`define SIC_I2C_PASSALL 7
`define SIC_OSC_RSVD 2'h2
`define SIC_CRC_MAX 16'hFFFF
`define SIC_MCLK_PERIOD_NS 8
`define SIC_WD_UNIT_NS 2000000
`define SIC_WD_UNIT_CYC (`SIC_WD_UNIT_NS / `SIC_MCLK_PERIOD_NS)
`endif

// ---- core/sic_pkg.sv ----
// Types shared by the serializer control and status bank
package sic_pkg;
   // Watchdog states, one-hot
   typedef enum logic [2:0] {
      SIC_WD_IDLE = 3'h1,
      SIC_WD_RUN = 3'h2,
      SIC_WD_EXPIRED = 3'h4
   } sic_wd_t;
   // Register access request from the serial control engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sic_req_t;
   // Forwarded serial access offered for remapping
   typedef struct packed {
      logic valid;
      logic [6:0] addr;
   } sic_fwd_t;
   // Whole state of the bank
   typedef struct packed {
      logic [7:0] alias_r, gp0, gp21, o4g3, o65, o7, dpc, osc, wdc, i2c;
      logic [15:0] crc_cnt;
      logic des_err, bist_err;
      logic link1, link2, pclk1, pclk2, strap1, strap2, de1, de2;
      logic [3:0] gin1, gin2;
      logic strap_cap, strap_seen, ovr18;
      sic_wd_t wd;
      logic [19:0] tick;
      logic [6:0] units;
      logic abort;
      logic [7:0] rdata;
      logic rvalid;
      logic [3:0] gout, goe, grx, aux_en, aux_val;
      logic de_act, video18, osc_lf;
      sic_fwd_t fwd;
   } sic_state_t;
endpackage

// ---- core/sic_regs.sv ----
// Control and status register bank of the serializer
//
// Functional notes
// - Alias-matched forward gets physical slave address
// - Zero alias disables remote slave access
// - Sixteen-bit CRC error count, two bytes
// - Self-test CRC flag, cleared on three events
// - Link CRC flag, cleared on loss/clear
// - Status bit two shows pixel clock
// - Status bit zero shows cable link
// - Local drive when enabled, output, not remote
// - Remote control forces output, remote value
// - Direction one input; enable one GPIO
// - Aux output driven when enable is one
// - Polarity bit five inverts data enable
// - Bit four picks I2S regeneration source
// - Bit two selects 18-bit video
// - Bit one selects audio transport kind
// - Mode status shows decode done, repeater
// - Strap in bit zero, register overrides
// - Bit three shows alternate frequency mode
// - Two-bit clock source select, one reserved
// - Bit zero shows self test enabled
// - Abort channel transaction after 2 ms units
// - Watchdog disable bit in bit zero
// - Pass-all forwards every non-local access
// - CRC clear input holds counters at zero
`timescale 1ns/10ps
`include "sic_defs.svh"
module sic_regs
   import sic_pkg::*;
#(
   parameter int WD_UNIT_CYCLES = `SIC_WD_UNIT_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Register access from the serial control engine
   input wire sic_req_t reg_req,
   output logic [7:0] reg_rdata_q,
   output logic reg_rvalid_q,
   // Identities kept elsewhere in the bank
   input wire logic [6:0] dev_id,
   input wire logic [6:0] des_id,
   input wire logic [6:0] slave_phys_id,
   // Forwarded access and its remapped result
   input wire sic_fwd_t fwd_req,
   output sic_fwd_t fwd_out_q,
   // Link and datapath events, same clock
   input wire logic bc_crc_err,
   input wire logic bist_active,
   input wire logic bist_start,
   input wire logic crc_clear,
   input wire logic mode_decode_done,
   input wire logic repeater_mode,
   input wire logic alt_freq_mode,
   input wire logic low_frequency_flag,
   // Pins from outside the clock domain
   input wire logic link_detect,
   input wire logic pclk_detect,
   input wire logic strap_18bit,
   input wire logic data_enable_strobe,
   // GPIO pins and their other users
   input wire logic [3:0] gpio_in,
   input wire logic [3:0] gpio_remote_val,
   input wire logic [3:0] norm_out,
   input wire logic [3:0] norm_oe,
   output logic [3:0] gpio_out_q,
   output logic [3:0] gpio_oe_q,
   output logic [3:0] gpio_rx_q,
   // Register-driven general outputs
   output logic [3:0] aux_en_q,
   output logic [3:0] aux_val_q,
   // Datapath controls
   output logic de_active_q,
   output logic video18_q,
   output logic i2s_regen_q,
   output logic i2s_frame_q,
   output logic [1:0] osc_src_q,
   output logic osc_lf_q,
   // Control channel watchdog
   input wire logic cc_txn_active,
   output logic cc_abort_q
);
   // Refuse a unit count the tick counter cannot hold
   initial begin
      if (WD_UNIT_CYCLES < 2 || WD_UNIT_CYCLES > 1048575) begin
         $error("WD_UNIT_CYCLES out of range");
      end
   end

   localparam logic [19:0] UNIT_LAST = 20'(WD_UNIT_CYCLES - 1);

   sic_state_t s_q; // Registered state
   sic_state_t s_d; // Next state

   // Pin GPIO settings {value, remote, direction, enable}
   function automatic logic [3:0] gpio_cfg(input sic_state_t s, input int n);
      logic [3:0] f;
      f = 4'h0;
      if (n == 0) begin
         f = s.gp0[3:0];
      end else if (n == 1) begin
         f = s.gp21[3:0];
      end else if (n == 2) begin
         f = s.gp21[7:4];
      end else begin
         f = s.o4g3[3:0];
      end
      return f;
   endfunction

   // Write decode: true when this offset is written
   function automatic logic hit(input sic_req_t r, input logic [7:0] ofs);
      return r.wr && (r.addr == ofs);
   endfunction

   // Next state
   always_comb begin
      logic [3:0] c; // Settings of the pin being decoded
      c = 4'h0;
      s_d = s_q;
      // Two-flop synchronisers for pins
      s_d.link1 = link_detect;
      s_d.link2 = s_q.link1;
      s_d.pclk1 = pclk_detect;
      s_d.pclk2 = s_q.pclk1;
      s_d.strap1 = strap_18bit;
      s_d.strap2 = s_q.strap1;
      s_d.de1 = data_enable_strobe;
      s_d.de2 = s_q.de1;
      s_d.gin1 = gpio_in;
      s_d.gin2 = s_q.gin1;
      s_d.grx = s_q.gin2;

      // Register writes, masked so reserved bits stay zero
      if (hit(reg_req, `SIC_OFS_ALIAS)) begin
         s_d.alias_r = reg_req.wdata & `SIC_MSK_ALIAS;
      end else if (hit(reg_req, `SIC_OFS_GP0)) begin
         s_d.gp0 = reg_req.wdata & `SIC_MSK_GP0;
      end else if (hit(reg_req, `SIC_OFS_GP21)) begin
         s_d.gp21 = reg_req.wdata & `SIC_MSK_GP21;
      end else if (hit(reg_req, `SIC_OFS_O4G3)) begin
         s_d.o4g3 = reg_req.wdata & `SIC_MSK_O4G3;
      end else if (hit(reg_req, `SIC_OFS_O65)) begin
         s_d.o65 = reg_req.wdata & `SIC_MSK_O65;
      end else if (hit(reg_req, `SIC_OFS_O7)) begin
         s_d.o7 = reg_req.wdata & `SIC_MSK_O7;
      end else if (hit(reg_req, `SIC_OFS_DPC)) begin
         s_d.dpc = reg_req.wdata & `SIC_MSK_DPC;
         s_d.ovr18 = 1'b1;
      end else if (hit(reg_req, `SIC_OFS_OSC)) begin
         // reserved source code is not taken
         if (reg_req.wdata[2:1] != `SIC_OSC_RSVD) begin
            s_d.osc = reg_req.wdata & `SIC_MSK_OSC;
         end
      end else if (hit(reg_req, `SIC_OFS_WDC)) begin
         s_d.wdc = reg_req.wdata & `SIC_MSK_WDC;
      end else if (hit(reg_req, `SIC_OFS_I2C)) begin
         s_d.i2c = reg_req.wdata & `SIC_MSK_I2C;
      end

      // Register reads, answered one cycle later
      s_d.rvalid = reg_req.rd;
      s_d.rdata = 8'h00;
      if (reg_req.addr == `SIC_OFS_ALIAS) begin
         s_d.rdata = s_q.alias_r;
      end else if (reg_req.addr == `SIC_OFS_CRCLO) begin
         s_d.rdata = s_q.crc_cnt[7:0];
      end else if (reg_req.addr == `SIC_OFS_CRCHI) begin
         s_d.rdata = s_q.crc_cnt[15:8];
      end else if (reg_req.addr == `SIC_OFS_STAT) begin
         s_d.rdata = {4'h0, s_q.bist_err, s_q.pclk2, s_q.des_err, s_q.link2};
      end else if (reg_req.addr == `SIC_OFS_GP0) begin
         s_d.rdata = s_q.gp0;
      end else if (reg_req.addr == `SIC_OFS_GP21) begin
         s_d.rdata = s_q.gp21;
      end else if (reg_req.addr == `SIC_OFS_O4G3) begin
         s_d.rdata = s_q.o4g3;
      end else if (reg_req.addr == `SIC_OFS_O65) begin
         s_d.rdata = s_q.o65;
      end else if (reg_req.addr == `SIC_OFS_O7) begin
         s_d.rdata = s_q.o7;
      end else if (reg_req.addr == `SIC_OFS_DPC) begin
         s_d.rdata = s_q.dpc;
      end else if (reg_req.addr == `SIC_OFS_MODE) begin
         s_d.rdata = {3'h0, mode_decode_done, alt_freq_mode, repeater_mode,
                      1'b0, s_q.video18};
      end else if (reg_req.addr == `SIC_OFS_OSC) begin
         // self test enabled in bit zero
         s_d.rdata = {s_q.osc[7:1], bist_active};
      end else if (reg_req.addr == `SIC_OFS_WDC) begin
         s_d.rdata = s_q.wdc;
      end else if (reg_req.addr == `SIC_OFS_I2C) begin
         s_d.rdata = s_q.i2c;
      end

      if (bc_crc_err && s_q.crc_cnt != `SIC_CRC_MAX) begin
         s_d.crc_cnt = s_q.crc_cnt + 16'h0001;
      end
      // self-test flag; a set beats a restart
      if (bist_start) begin
         s_d.bist_err = 1'b0;
      end
      if (bc_crc_err && bist_active) begin
         s_d.bist_err = 1'b1;
      end
      if (bc_crc_err && !bist_active) begin
         s_d.des_err = 1'b1;
      end
      if (!s_q.link2) begin
         s_d.bist_err = 1'b0;
         s_d.des_err = 1'b0;
      end
      // clear holds counters and flags at zero
      if (crc_clear) begin
         s_d.crc_cnt = 16'h0000;
         s_d.bist_err = 1'b0;
         s_d.des_err = 1'b0;
      end

      if (mode_decode_done && !s_q.strap_seen) begin
         s_d.strap_seen = 1'b1;
         s_d.strap_cap = s_q.strap2;
      end
      // 18-bit select, strap until first write
      s_d.video18 = s_q.ovr18 ? s_q.dpc[`SIC_DPC_V18] : s_q.strap_cap;

      s_d.de_act = s_q.de2 ^ s_q.dpc[`SIC_DPC_DEPOL];
      // low frequency mode pins the oscillator
      s_d.osc_lf = low_frequency_flag && (s_q.osc[2:1] != 2'h0);

      s_d.aux_en = {s_q.o7[0], s_q.o65[4], s_q.o65[0], s_q.o4g3[4]};
      s_d.aux_val = {s_q.o7[3], s_q.o65[7], s_q.o65[3], s_q.o4g3[7]};

      // GPIO pin drive
      for (int n = 0; n < 4; n++) begin
         c = gpio_cfg(s_q, n);
         if (c[2]) begin
            s_d.goe[n] = 1'b1;
            s_d.gout[n] = gpio_remote_val[n];
         end else if (c[0] && !c[1]) begin
            s_d.goe[n] = 1'b1;
            s_d.gout[n] = c[3];
         end else if (c[0]) begin
            s_d.goe[n] = 1'b0;
            s_d.gout[n] = 1'b0;
         end else begin
            s_d.goe[n] = norm_oe[n];
            s_d.gout[n] = norm_out[n];
         end
      end

      // Forwarding decision for an offered access
      s_d.fwd.valid = 1'b0;
      s_d.fwd.addr = fwd_req.addr;
      if (fwd_req.valid && fwd_req.addr != dev_id) begin
         if (s_q.alias_r[7:1] != 7'h00 && fwd_req.addr == s_q.alias_r[7:1]) begin
            s_d.fwd.valid = 1'b1;
            s_d.fwd.addr = slave_phys_id;
         end else if (s_q.i2c[`SIC_I2C_PASSALL]) begin
            s_d.fwd.valid = 1'b1;
         end else if (des_id != 7'h00 && fwd_req.addr == des_id) begin
            s_d.fwd.valid = 1'b1;
         end
      end

      // Control channel watchdog
      s_d.abort = 1'b0;
      case (s_q.wd)
         SIC_WD_IDLE: begin
            if (!s_q.wdc[`SIC_WDC_DIS] && cc_txn_active) begin
               s_d.wd = SIC_WD_RUN;
               s_d.tick = 20'h00000;
               s_d.units = 7'h00;
            end
         end
         SIC_WD_RUN: begin
            if (s_q.wdc[`SIC_WDC_DIS] || !cc_txn_active) begin
               s_d.wd = SIC_WD_IDLE;
            end else if (s_q.tick == UNIT_LAST) begin
               s_d.tick = 20'h00000;
               s_d.units = s_q.units + 7'h01;
               if (s_q.units + 7'h01 >= s_q.wdc[7:1]) begin
                  s_d.wd = SIC_WD_EXPIRED;
                  s_d.abort = 1'b1;
               end
            end else begin
               s_d.tick = s_q.tick + 20'h00001;
            end
         end
         SIC_WD_EXPIRED: begin
            // Wait for the aborted transaction to drop
            if (!cc_txn_active) begin
               s_d.wd = SIC_WD_IDLE;
            end
         end
         default: begin
            s_d.wd = SIC_WD_IDLE;
         end
      endcase
   end

   // State register with synchronous reset
   always_ff @(posedge mclk) begin
      if (srst) begin
         s_q <= '0;
         s_q.wdc <= `SIC_RST_WDC;
         s_q.i2c <= `SIC_RST_I2C;
         s_q.wd <= SIC_WD_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign reg_rdata_q = s_q.rdata;
   assign reg_rvalid_q = s_q.rvalid;
   assign fwd_out_q = s_q.fwd;
   assign gpio_out_q = s_q.gout;
   assign gpio_oe_q = s_q.goe;
   assign gpio_rx_q = s_q.grx;
   assign aux_en_q = s_q.aux_en;
   assign aux_val_q = s_q.aux_val;
   assign de_active_q = s_q.de_act;
   assign video18_q = s_q.video18;
   assign i2s_regen_q = s_q.dpc[`SIC_DPC_I2SREGEN];
   assign i2s_frame_q = s_q.dpc[`SIC_DPC_I2STRANS];
   assign osc_src_q = s_q.osc[2:1];
   assign osc_lf_q = s_q.osc_lf;
   assign cc_abort_q = s_q.abort;

   // Alias hit yields the physical address
   alias_remap_a: assert property (@(posedge mclk) disable iff (srst)
      fwd_req.valid && fwd_req.addr != dev_id && s_q.alias_r[7:1] != 7'h00 &&
      fwd_req.addr == s_q.alias_r[7:1]
      |=> fwd_out_q.valid && fwd_out_q.addr == $past(slave_phys_id))
      else $error("alias not remapped");
   // Zero alias gives no remote slave path
   alias_zero_a: assert property (@(posedge mclk) disable iff (srst)
      fwd_req.valid && s_q.alias_r == 8'h00 && !s_q.i2c[`SIC_I2C_PASSALL] &&
      fwd_req.addr != des_id |=> !fwd_out_q.valid)
      else $error("forward with zero alias");
   // Counter steps by one per error
   crc_count_a: assert property (@(posedge mclk) disable iff (srst)
      bc_crc_err && !crc_clear && s_q.crc_cnt != `SIC_CRC_MAX
      |=> s_q.crc_cnt == $past(s_q.crc_cnt) + 16'h0001)
      else $error("crc count did not step");
   // Self-test error sets with link up
   bist_err_a: assert property (@(posedge mclk) disable iff (srst)
      bc_crc_err && bist_active && !crc_clear && s_q.link2 |=> s_q.bist_err)
      else $error("bist flag not set");
   // Link loss clears the link error flag
   des_err_clr_a: assert property (@(posedge mclk) disable iff (srst)
      !s_q.link2 |=> !s_q.des_err)
      else $error("des flag survived link loss");
   // Local drive of pin zero
   gpio_drive_a: assert property (@(posedge mclk) disable iff (srst)
      gpio_cfg(s_q, 0) ==? 4'b?001 |=> gpio_oe_q[0] && gpio_out_q[0] == $past(s_q.gp0[3]))
      else $error("pin zero not driven locally");
   // Remote drive of pin one
   gpio_remote_a: assert property (@(posedge mclk) disable iff (srst)
      gpio_cfg(s_q, 1) ==? 4'b?1?? |=> gpio_oe_q[1] &&
      gpio_out_q[1] == $past(gpio_remote_val[1]))
      else $error("pin one not remote driven");
   // Data enable pin, through its synchroniser, follows polarity
   de_polarity_a: assert property (@(posedge mclk) disable iff (srst)
      ##3 de_active_q == ($past(data_enable_strobe, 3) ^ $past(s_q.dpc[`SIC_DPC_DEPOL])))
      else $error("data enable polarity wrong");
   // Abort only from an enabled watchdog
   wd_enable_a: assert property (@(posedge mclk) disable iff (srst)
      cc_abort_q |-> !$past(s_q.wdc[`SIC_WDC_DIS]) && $past(cc_txn_active))
      else $error("abort while disabled");
   // Pass-all forwards non-local accesses
   pass_all_a: assert property (@(posedge mclk) disable iff (srst)
      fwd_req.valid && s_q.i2c[`SIC_I2C_PASSALL] && fwd_req.addr != dev_id
      |=> fwd_out_q.valid)
      else $error("pass-all access dropped");
endmodule

// ---- testbench/sic_remote_model.sv ----
// Remote deserializer model: back channel errors, remote GPIO values, stalled transactions
`timescale 1ns/10ps
module sic_remote_model (
   // Clock
   input wire logic mclk,
   // Watchdog answer from the bank
   input wire logic cc_abort_q,
   // Drive toward the bank
   output logic bc_crc_err,
   output logic cc_txn_active,
   output logic [3:0] gpio_remote_val
);
   // Idle levels from time zero
   initial begin
      bc_crc_err = 1'b0;
      cc_txn_active = 1'b0;
      gpio_remote_val = 4'h5;
   end
   // One-cycle error pulses with an idle cycle between them
   task automatic send_errors(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge mclk) bc_crc_err = 1'b1;
         @(negedge mclk) bc_crc_err = 1'b0;
      end
   endtask
   // transaction never answered
   // Holds the channel busy until abort or limit, returns cycles waited
   task automatic hang(input int limit, output int cyc);
      cyc = 0;
      @(negedge mclk) cc_txn_active = 1'b1;
      while (cyc < limit && cc_abort_q !== 1'b1) begin
         @(negedge mclk) cyc++;
      end
      cc_txn_active = 1'b0;
      // Idle cycle before any new transaction
      @(negedge mclk);
   endtask
endmodule

// ---- testbench/sic_regs_tb.sv ----
// Self-checking bench for the serializer control and status bank
`timescale 1ns/10ps
module sic_regs_tb
   import sic_pkg::*;
;
   localparam int WD_U = 4;
   // Clock, reset and register bus
   logic mclk, srst;
   sic_req_t reg_req;
   logic [7:0] reg_rdata_q;
   logic reg_rvalid_q;
   // Identities and forwarding
   logic [6:0] dev_id, des_id, slave_phys_id;
   sic_fwd_t fwd_req, fwd_out_q;
   // Events and pins
   logic bc_crc_err, bist_active, bist_start, crc_clear, mode_decode_done;
   logic repeater_mode, alt_freq_mode, low_frequency_flag;
   logic link_detect, pclk_detect, strap_18bit, data_enable_strobe;
   logic cc_txn_active, cc_abort_q;
   // GPIO and datapath outputs
   logic [3:0] gpio_in, gpio_remote_val, norm_out, norm_oe;
   logic [3:0] gpio_out_q, gpio_oe_q, gpio_rx_q, aux_en_q, aux_val_q;
   logic de_active_q, video18_q, i2s_regen_q, i2s_frame_q, osc_lf_q;
   logic [1:0] osc_src_q;
   // Bookkeeping
   int errors, cmp_count, ticks, cyc;
   // Offsets with reset values and values after writing all ones
   logic [7:0] ofs [12] = '{8'h08, 8'h0A, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h14,
      8'h16, 8'h17, 8'h09};
   logic [7:0] rst_v [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'hFE, 8'h5E, 8'h00};
   logic [7:0] msk_v [12] = '{8'hFE, 8'h00, 8'h0F, 8'hFF, 8'h9F, 8'h99, 8'h09, 8'h36, 8'h06,
      8'hFF, 8'hFF, 8'h00};
   // Bank under test, short watchdog unit
   sic_regs #(.WD_UNIT_CYCLES(WD_U)) i_sic_regs (.mclk(mclk), .srst(srst),
      .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
      .dev_id(dev_id), .des_id(des_id), .slave_phys_id(slave_phys_id),
      .fwd_req(fwd_req), .fwd_out_q(fwd_out_q), .bc_crc_err(bc_crc_err),
      .bist_active(bist_active), .bist_start(bist_start), .crc_clear(crc_clear),
      .mode_decode_done(mode_decode_done), .repeater_mode(repeater_mode),
      .alt_freq_mode(alt_freq_mode), .low_frequency_flag(low_frequency_flag),
      .link_detect(link_detect), .pclk_detect(pclk_detect), .strap_18bit(strap_18bit),
      .data_enable_strobe(data_enable_strobe), .gpio_in(gpio_in),
      .gpio_remote_val(gpio_remote_val), .norm_out(norm_out), .norm_oe(norm_oe),
      .gpio_out_q(gpio_out_q), .gpio_oe_q(gpio_oe_q), .gpio_rx_q(gpio_rx_q),
      .aux_en_q(aux_en_q), .aux_val_q(aux_val_q), .de_active_q(de_active_q),
      .video18_q(video18_q), .i2s_regen_q(i2s_regen_q), .i2s_frame_q(i2s_frame_q),
      .osc_src_q(osc_src_q), .osc_lf_q(osc_lf_q), .cc_txn_active(cc_txn_active),
      .cc_abort_q(cc_abort_q));
   // Far side of the control channel
   sic_remote_model i_sic_remote_model (.mclk(mclk), .cc_abort_q(cc_abort_q),
      .bc_crc_err(bc_crc_err), .cc_txn_active(cc_txn_active),
      .gpio_remote_val(gpio_remote_val));
   // Clock at 8 ns
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Verdict and end of run
   task automatic conclude();
      if (errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Cycle ceiling against a hang
   always @(posedge mclk) begin
      ticks++;
      if (ticks == 6000) begin
         errors++;
         conclude();
      end
   end
   // Compare one result
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Idle cycles
   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // One-cycle write request
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk) reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge mclk) reg_req.wr = 1'b0;
   endtask
   // One-cycle read request, answer looked at in the cycle after
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge mclk) reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge mclk) reg_req.rd = 1'b0;
      chk({7'h00, reg_rvalid_q, reg_rdata_q}, {8'h01, exp});
   endtask
   // One-cycle forward offer, result looked at one cycle later
   task automatic fwd_chk(input logic [6:0] a, input logic [7:0] exp);
      @(negedge mclk) fwd_req = '{valid: 1'b1, addr: a};
      @(negedge mclk) fwd_req.valid = 1'b0;
      chk({8'h00, fwd_out_q.valid ? 8'(fwd_out_q) : 8'h00}, {8'h00, exp});
   endtask
   // Main sequence
   initial begin
      srst = 1'b1;
      reg_req = '0;
      fwd_req = '0;
      {bist_active, bist_start, crc_clear, mode_decode_done, link_detect} = '0;
      {pclk_detect, data_enable_strobe, repeater_mode, alt_freq_mode} = '0;
      {low_frequency_flag, strap_18bit} = 2'h3;
      {dev_id, des_id, slave_phys_id} = {7'h1A, 7'h2B, 7'h33};
      {gpio_in, norm_out, norm_oe} = {4'h6, 4'hA, 4'h5};
      idle(10);
      srst = 1'b0;
      // Reset values, unmapped read
      for (int i = 0; i < 12; i++) rd_chk(ofs[i], rst_v[i]);
      rd_chk(8'h0C, 8'h00);
      // Strap captured, mode flags reported
      {mode_decode_done, repeater_mode, alt_freq_mode} = 3'h7;
      idle(5);
      rd_chk(8'h13, 8'h1D);
      chk(16'(video18_q), 16'h1);
      // All ones everywhere, reserved and read-only bits stay clear
      for (int i = 0; i < 12; i++) wr(ofs[i], 8'hFF);
      for (int i = 0; i < 12; i++) rd_chk(ofs[i], msk_v[i]);
      wr(8'h14, 8'h04);
      rd_chk(8'h14, 8'h06);
      idle(3);
      chk({aux_en_q, aux_val_q}, 16'hFF);
      chk({gpio_oe_q, gpio_out_q}, 16'hF5);
      chk({i2s_regen_q, i2s_frame_q, de_active_q, video18_q}, 16'hF);
      chk({osc_src_q, osc_lf_q}, 16'h7);
      // Register clears 18-bit, data enable follows pin
      wr(8'h12, 8'h00);
      {data_enable_strobe, low_frequency_flag} = 2'h2;
      idle(6);
      chk({de_active_q, video18_q, i2s_regen_q, i2s_frame_q, osc_lf_q}, 16'h10);
      rd_chk(8'h13, 8'h1C);
      // Local drive, input and normal function on pin zero
      wr(8'h0E, 8'h00);
      wr(8'h0F, 8'h00);
      wr(8'h0D, 8'h09);
      idle(3);
      chk({gpio_oe_q, gpio_out_q}, 16'h5B);
      wr(8'h0D, 8'h0B);
      idle(3);
      chk(16'(gpio_oe_q[0]), 16'h0);
      chk(16'(gpio_rx_q), 16'h6);
      wr(8'h0D, 8'h08);
      idle(3);
      chk({gpio_oe_q, gpio_out_q}, 16'h5A);
      // Error counts over 8 bits, flags and their clears
      {link_detect, pclk_detect} = 2'h3;
      idle(5);
      i_sic_remote_model.send_errors(260);
      rd_chk(8'h0A, 8'h04);
      rd_chk(8'h0B, 8'h01);
      rd_chk(8'h0C, 8'h07);
      bist_active = 1'b1;
      i_sic_remote_model.send_errors(1);
      rd_chk(8'h0C, 8'h0F);
      rd_chk(8'h14, 8'h07);
      @(negedge mclk) bist_start = 1'b1;
      @(negedge mclk) bist_start = 1'b0;
      rd_chk(8'h0C, 8'h07);
      i_sic_remote_model.send_errors(1);
      crc_clear = 1'b1;
      idle(2);
      rd_chk(8'h0A, 8'h00);
      rd_chk(8'h0C, 8'h05);
      {crc_clear, bist_active} = 2'h0;
      i_sic_remote_model.send_errors(1);
      rd_chk(8'h0A, 8'h01);
      link_detect = 1'b0;
      idle(6);
      rd_chk(8'h0C, 8'h04);
      // Forwarding with zero alias, then alias, then pass-all
      wr(8'h08, 8'h00);
      wr(8'h17, 8'h5E);
      fwd_chk(7'h50, 8'h00);
      fwd_chk(7'h2B, 8'hAB);
      fwd_chk(7'h11, 8'h00);
      wr(8'h08, 8'hA0);
      fwd_chk(7'h50, 8'hB3);
      wr(8'h17, 8'hDE);
      fwd_chk(7'h11, 8'h91);
      fwd_chk(7'h1A, 8'h00);
      fwd_chk(7'h50, 8'hB3);
      // Watchdog of three units, then disabled
      wr(8'h16, 8'h06); // nonzero timeout field
      i_sic_remote_model.hang(40, cyc);
      chk(16'(cyc), 16'(1 + 3 * WD_U));
      wr(8'h16, 8'h07);
      i_sic_remote_model.hang(40, cyc);
      chk(16'(cyc), 16'd40);
      conclude();
   end
endmodule
